/* inc/serial_host_port_pkg.sv */
`default_nettype none
package serial_host_port_pkg;

    localparam int ADDR_W = 16;
    localparam int DATA_W = 24;
    localparam int RX_DEPTH = 10;

    // register addresses in core data space
    localparam logic [15:0] CLOCK_CONTROL_ADDR = 16'hFFF0;
    localparam logic [15:0] CONTROL_STATUS_ADDR = 16'hFFF1;
    localparam logic [15:0] DATA_ADDR = 16'hFFF3;

    // clock control fields
    localparam int CLOCK_PHASE_BIT = 0;
    localparam int CLOCK_POLARITY_BIT = 1;
    localparam int PRESCALER_SELECT_BIT = 2;
    localparam int CLOCK_DIVIDER_LSB = 3;
    localparam int CLOCK_DIVIDER_W = 6;
    localparam int CLOCK_FIELD_W = 9;
    localparam int CLOCK_DIVIDER_MSB = CLOCK_DIVIDER_LSB + CLOCK_DIVIDER_W - 1;
    localparam logic [8:0] CLOCK_CONTROL_RESET = 9'h001;

    // control/status fields
    localparam int PORT_ENABLE_BIT = 0;
    localparam int MASTER_SELECT_BIT = 6;
    localparam int TX_IE_BIT = 11;
    localparam int RX_IE0_BIT = 12;
    localparam int RX_IE1_BIT = 13;
    localparam int BUS_IE_BIT = 10;
    localparam int TX_UNDERRUN_BIT = 14;
    localparam int TX_EMPTY_BIT = 15;
    localparam int RX_NOT_EMPTY_BIT = 17;
    localparam int RX_FULL_BIT = 18;
    localparam int RX_OVERRUN_BIT = 19;
    localparam int BUS_ERROR_BIT = 20;
    localparam logic [23:0] CONTROL_WRITE_MASK = 24'h003FFF;

    // clock generator timing: one serial bit period at least two cycles
    localparam int PRESCALE_FACTOR = 8;

    // event vectors
    localparam logic [15:0] VEC_TX_DATA = 16'h0020;
    localparam logic [15:0] VEC_TX_UNDERRUN = 16'h0022;
    localparam logic [15:0] VEC_RX_NOT_EMPTY = 16'h0024;
    localparam logic [15:0] VEC_RESERVED = 16'h0026;
    localparam logic [15:0] VEC_RX_FULL = 16'h0028;
    localparam logic [15:0] VEC_RX_OVERRUN = 16'h002A;
    localparam logic [15:0] VEC_BUS_ERROR = 16'h002C;

    typedef enum logic [6:0] {
        EV_NONE = 7'h01,
        EV_BUS_ERROR = 7'h02,
        EV_RX_OVERRUN = 7'h04,
        EV_TX_UNDERRUN = 7'h08,
        EV_RX_FULL = 7'h10,
        EV_TX_DATA = 7'h20,
        EV_RX_NOT_EMPTY = 7'h40
    } event_sel_t;

endpackage : serial_host_port_pkg
`default_nettype wire

/* core/serial_host_clock_irq_map.sv */
// Operation
// - master mode: internal generator makes bit clock
// - slave mode: generator off, no clock driven
// - master select 0: external clock clocks port
// - events map to fixed vector addresses
// - fixed priority from bus error downward
// - receive fifo and transmit share one address
// - receive fifo ten words of 24 bits
// - clock control decoded at FFF0
// - control/status decoded at FFF1
// - reserved bits read zero
// - reset sets phase, clears polarity
// - transmit write clears transmit-empty flag while port enabled
`timescale 1ns/1ps
`default_nettype none
module serial_host_clock_irq_map
    import serial_host_port_pkg::*;
#(
    parameter int RX_WORDS = RX_DEPTH
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // core data space access
    input wire logic [15:0] addr_i,
    input wire logic rd_i,
    input wire logic wr_i,
    input wire logic [23:0] wdata_i,
    output logic [23:0] rdata_o,
    // shift engine side
    input wire logic rx_push_i,
    input wire logic [23:0] rx_word_i,
    input wire logic tx_pull_i,
    input wire logic tx_underrun_i,
    input wire logic bus_error_i,
    output logic [23:0] tx_word_o,
    // serial clock pin, three signals, and port clock
    input wire logic sck_in_i,
    output logic sck_out_o,
    output logic sck_oe_n_o,
    output logic port_clk_o,
    // event request
    output logic event_req_o,
    output logic [15:0] event_vector_o
);

    logic [8:0] clk_ctl_q;
    logic [23:0] ctl_q;
    logic [23:0] tx_q;
    logic tx_empty_q;
    logic tx_underrun_q;
    logic rx_overrun_q;
    logic bus_error_q;
    logic [23:0] fifo_q [RX_WORDS];
    logic [3:0] rd_ptr_q;
    logic [3:0] wr_ptr_q;
    logic [4:0] count_q;
    logic [2:0] sck_sync_q;
    logic sck_ext_q;
    logic [9:0] div_cnt_q;
    logic sck_gen_q;
    logic [23:0] rdata_q;
    logic req_q;
    logic [15:0] vec_q;
    event_sel_t sel_d;

    logic wr_clk, wr_ctl, wr_tx, rd_rx, do_pop, do_push;
    logic master, enabled, rx_full, rx_nempty;
    logic [9:0] div_limit;

    assign wr_clk = wr_i && addr_i == CLOCK_CONTROL_ADDR;
    assign wr_ctl = wr_i && addr_i == CONTROL_STATUS_ADDR;
    assign wr_tx = wr_i && addr_i == DATA_ADDR;
    assign rd_rx = rd_i && addr_i == DATA_ADDR;
    assign master = ctl_q[MASTER_SELECT_BIT];
    assign enabled = ctl_q[PORT_ENABLE_BIT];
    assign rx_full = count_q == 5'(RX_WORDS);
    assign rx_nempty = count_q != 5'h00;
    assign do_pop = rd_rx && rx_nempty;
    assign do_push = rx_push_i && enabled && (!rx_full || do_pop);

    // registers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            clk_ctl_q <= CLOCK_CONTROL_RESET;
        end else if (wr_clk) begin
            clk_ctl_q <= wdata_i[CLOCK_FIELD_W-1:0];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctl_q <= 24'h000000;
        end else if (wr_ctl) begin
            ctl_q <= wdata_i & CONTROL_WRITE_MASK;
        end
    end

    // transmit register and empty flag; a pull in the write cycle loses
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_q <= 24'h000000;
            tx_empty_q <= 1'b1;
        end else if (!enabled) begin
            tx_empty_q <= 1'b1;
            if (wr_tx) begin
                tx_q <= wdata_i;
            end
        end else if (wr_tx) begin
            tx_q <= wdata_i;
            tx_empty_q <= 1'b0;
        end else if (tx_pull_i) begin
            tx_empty_q <= 1'b1;
        end
    end

    // sticky error flags, set wins over a clearing write
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_underrun_q <= 1'b0;
            rx_overrun_q <= 1'b0;
            bus_error_q <= 1'b0;
        end else begin
            tx_underrun_q <= (tx_underrun_i && enabled) ||
                (tx_underrun_q && !(wr_ctl && !wdata_i[TX_UNDERRUN_BIT]));
            rx_overrun_q <= (rx_push_i && enabled && rx_full && !do_pop) ||
                (rx_overrun_q && !(wr_ctl && !wdata_i[RX_OVERRUN_BIT]));
            bus_error_q <= (bus_error_i && enabled) ||
                (bus_error_q && !(wr_ctl && !wdata_i[BUS_ERROR_BIT]));
        end
    end

    // receive fifo
    always_ff @(posedge clk_i) begin
        if (do_push) begin
            fifo_q[wr_ptr_q] <= rx_word_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_ptr_q <= 4'h0;
            wr_ptr_q <= 4'h0;
            count_q <= 5'h00;
        end else if (!enabled) begin
            rd_ptr_q <= 4'h0;
            wr_ptr_q <= 4'h0;
            count_q <= 5'h00;
        end else begin
            if (do_push) begin
                wr_ptr_q <= (wr_ptr_q == 4'(RX_WORDS - 1)) ? 4'h0
                    : wr_ptr_q + 4'h1;
            end
            if (do_pop) begin
                rd_ptr_q <= (rd_ptr_q == 4'(RX_WORDS - 1)) ? 4'h0
                    : rd_ptr_q + 4'h1;
            end
            count_q <= count_q + 5'(do_push) - 5'(do_pop);
        end
    end

    // read data, registered one cycle after the read
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_q <= 24'h000000;
        end else if (rd_i) begin
            unique case (addr_i)
                CLOCK_CONTROL_ADDR: rdata_q <= 24'(clk_ctl_q);
                CONTROL_STATUS_ADDR: begin
                    rdata_q <= ctl_q;
                    rdata_q[TX_UNDERRUN_BIT] <= tx_underrun_q;
                    rdata_q[TX_EMPTY_BIT] <= tx_empty_q;
                    rdata_q[RX_NOT_EMPTY_BIT] <= rx_nempty;
                    rdata_q[RX_FULL_BIT] <= rx_full;
                    rdata_q[RX_OVERRUN_BIT] <= rx_overrun_q;
                    rdata_q[BUS_ERROR_BIT] <= bus_error_q;
                end
                DATA_ADDR: rdata_q <= rx_nempty ? fifo_q[rd_ptr_q]
                    : 24'h000000;
                default: rdata_q <= 24'h000000;
            endcase
        end
    end

    // external clock synchroniser, change taken when stages 2 and 3 agree
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sck_sync_q <= 3'b000;
            sck_ext_q <= 1'b0;
        end else begin
            sck_sync_q <= {sck_sync_q[1:0], sck_in_i};
            if (sck_sync_q[1] == sck_sync_q[2]) begin
                sck_ext_q <= sck_sync_q[2];
            end
        end
    end

    // internal bit clock generator, idle at polarity level
    assign div_limit = clk_ctl_q[PRESCALER_SELECT_BIT]
        ? 10'(({4'h0, clk_ctl_q[CLOCK_DIVIDER_MSB:CLOCK_DIVIDER_LSB]} + 10'h1)
            * 10'(PRESCALE_FACTOR))
        : ({4'h0, clk_ctl_q[CLOCK_DIVIDER_MSB:CLOCK_DIVIDER_LSB]} + 10'h1);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_cnt_q <= 10'h000;
            sck_gen_q <= 1'b0;
        end else if (!(master && enabled)) begin
            div_cnt_q <= 10'h000;
            sck_gen_q <= clk_ctl_q[CLOCK_POLARITY_BIT];
        end else if (div_cnt_q + 10'h1 >= div_limit) begin
            div_cnt_q <= 10'h000;
            sck_gen_q <= !sck_gen_q;
        end else begin
            div_cnt_q <= div_cnt_q + 10'h1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sck_out_o <= 1'b0;
            sck_oe_n_o <= 1'b1;
            port_clk_o <= 1'b0;
        end else begin
            sck_out_o <= sck_gen_q;
            sck_oe_n_o <= !(master && enabled);
            port_clk_o <= master ? sck_gen_q : sck_ext_q;
        end
    end

    // event selection in fixed priority, enabled events only
    always_comb begin
        sel_d = EV_NONE;
        if (ctl_q[BUS_IE_BIT] && bus_error_q) begin
            sel_d = EV_BUS_ERROR;
        end else if (ctl_q[RX_IE1_BIT] && rx_overrun_q) begin
            sel_d = EV_RX_OVERRUN;
        end else if (ctl_q[TX_IE_BIT] && tx_underrun_q) begin
            sel_d = EV_TX_UNDERRUN;
        end else if (ctl_q[RX_IE1_BIT] && rx_full) begin
            sel_d = EV_RX_FULL;
        end else if (ctl_q[TX_IE_BIT] && tx_empty_q && enabled) begin
            sel_d = EV_TX_DATA;
        end else if (ctl_q[RX_IE0_BIT] && rx_nempty) begin
            sel_d = EV_RX_NOT_EMPTY;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            req_q <= 1'b0;
            vec_q <= 16'h0000;
        end else begin
            req_q <= sel_d != EV_NONE;
            unique case (sel_d)
                EV_NONE: vec_q <= 16'h0000;
                EV_BUS_ERROR: vec_q <= VEC_BUS_ERROR;
                EV_RX_OVERRUN: vec_q <= VEC_RX_OVERRUN;
                EV_TX_UNDERRUN: vec_q <= VEC_TX_UNDERRUN;
                EV_RX_FULL: vec_q <= VEC_RX_FULL;
                EV_TX_DATA: vec_q <= VEC_TX_DATA;
                EV_RX_NOT_EMPTY: vec_q <= VEC_RX_NOT_EMPTY;
            endcase
        end
    end

    assign rdata_o = rdata_q;
    assign tx_word_o = tx_q;
    assign event_req_o = req_q;
    assign event_vector_o = vec_q;

    // assertions
    sequence tx_write_s;
        wr_tx && enabled;
    endsequence

    tx_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        tx_write_s |=> !tx_empty_q)
        else $error("transmit write did not clear empty flag");
    no_reserved_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        vec_q != VEC_RESERVED)
        else $error("reserved vector raised");
    bus_prio_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (bus_error_q && ctl_q[BUS_IE_BIT]) |=> vec_q == VEC_BUS_ERROR)
        else $error("bus error not served first");
    slave_quiet_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !master |=> sck_oe_n_o)
        else $error("slave drives clock");
    master_clock_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        master |=> port_clk_o == $past(sck_gen_q))
        else $error("master port clock not from generator");
    slave_clock_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !master |=> port_clk_o == $past(sck_ext_q))
        else $error("slave port clock not external");
    fifo_bound_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        count_q <= 5'(RX_WORDS))
        else $error("receive fifo over depth");
    clk_read_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (rd_i && addr_i == CLOCK_CONTROL_ADDR) |=>
            rdata_o == 24'($past(clk_ctl_q)))
        else $error("clock control readback wrong");
    reserved_zero_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (rd_i && addr_i == CONTROL_STATUS_ADDR) |=>
            rdata_o[23:21] == 3'b000 && rdata_o[16] == 1'b0)
        else $error("reserved bits not zero");

endmodule : serial_host_clock_irq_map
`default_nettype wire

/* bench/serial_peer_model.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_peer_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // frame request from the bench
    input wire logic frame_i,
    // serial clock made by the external master
    output logic sck_o
);
    // half period of 4 chip cycles, well under the external clock limit
    localparam int HALF = 4;
    logic [2:0] cnt_q;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= 3'h0;
            sck_o <= 1'b0;
        end else if (!frame_i) begin
            cnt_q <= 3'h0;
            sck_o <= 1'b0;
        end else if (cnt_q == 3'(HALF - 1)) begin
            cnt_q <= 3'h0;
            sck_o <= ~sck_o;
        end else begin
            cnt_q <= cnt_q + 3'h1;
        end
    end
endmodule : serial_peer_model
`default_nettype wire

/* bench/serial_host_clock_irq_map_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin \
    n_checks++; \
    if ((got) !== (ex)) begin \
        failures++; \
        $display("[FAIL] %s expected %h seen %h", nm, ex, got); \
    end \
end
module serial_host_clock_irq_map_tb_top;
    import serial_host_port_pkg::*;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [15:0] addr_i = 16'h0000;
    logic rd_i = 1'b0, wr_i = 1'b0, frame = 1'b0;
    logic [23:0] wdata_i = 24'h000000, rx_word_i = 24'h000000, d;
    logic rx_push_i = 1'b0, tx_pull_i = 1'b0;
    logic tx_underrun_i = 1'b0, bus_error_i = 1'b0;
    logic [23:0] rdata_o, tx_word_o;
    logic sck_in, sck_out_o, sck_oe_n_o, port_clk_o, event_req_o;
    logic [15:0] event_vector_o;
    logic sck_p = 1'b0, pc_p = 1'b0, si_p = 1'b0;
    int failures = 0, n_checks = 0, n_sck = 0, n_pc = 0, n_si = 0;

    always #25 clk_i = ~clk_i;

    serial_host_clock_irq_map serial_host_clock_irq_map_inst (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .rd_i(rd_i),
        .wr_i(wr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
        .rx_push_i(rx_push_i), .rx_word_i(rx_word_i),
        .tx_pull_i(tx_pull_i), .tx_underrun_i(tx_underrun_i),
        .bus_error_i(bus_error_i), .tx_word_o(tx_word_o),
        .sck_in_i(sck_in), .sck_out_o(sck_out_o), .sck_oe_n_o(sck_oe_n_o),
        .port_clk_o(port_clk_o), .event_req_o(event_req_o),
        .event_vector_o(event_vector_o));
    serial_peer_model serial_peer_model_inst (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .frame_i(frame), .sck_o(sck_in));

    // edge counters for the clock paths
    always @(posedge clk_i) begin
        sck_p <= sck_out_o;
        pc_p <= port_clk_o;
        si_p <= sck_in;
        if (sck_out_o !== sck_p) n_sck++;
        if (port_clk_o === 1'b1 && pc_p === 1'b0) n_pc++;
        if (sck_in === 1'b1 && si_p === 1'b0) n_si++;
        if (event_vector_o === VEC_RESERVED)
            `CHK("reserved vector", 16'h0000, event_vector_o)
    end

    task automatic finish_test();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test

    task automatic tend(input string s);
        $display("test %s done", s);
    endtask : tend

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : cyc

    task automatic wr(input logic [15:0] a, input logic [23:0] v);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr

    task automatic rd(input logic [15:0] a, output logic [23:0] v);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        v = rdata_o;
    endtask : rd

    task automatic chk_rd(input logic [15:0] a, input logic [23:0] ex,
                          input string nm);
        logic [23:0] v;
        rd(a, v);
        `CHK(nm, ex, v)
    endtask : chk_rd

    // 0 push, 1 pull, 2 underrun, 3 bus error
    task automatic pulse(input int k, input logic [23:0] w);
        @(posedge clk_i);
        rx_word_i <= w;
        case (k)
            0: rx_push_i <= 1'b1;
            1: tx_pull_i <= 1'b1;
            2: tx_underrun_i <= 1'b1;
            default: bus_error_i <= 1'b1;
        endcase
        @(posedge clk_i);
        rx_push_i <= 1'b0;
        tx_pull_i <= 1'b0;
        tx_underrun_i <= 1'b0;
        bus_error_i <= 1'b0;
    endtask : pulse

    task automatic vec(input logic [15:0] ex, input string nm);
        cyc(3);
        `CHK(nm, ex, event_vector_o)
        `CHK("event req", ex != 16'h0000, event_req_o)
    endtask : vec

    initial begin
        repeat (4000) @(posedge clk_i);
        failures++;
        finish_test();
    end

    initial begin
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        cyc(1);
        `CHK("oe reset", 1'b1, sck_oe_n_o)
        chk_rd(CLOCK_CONTROL_ADDR, 24'h000001, "clock reset");
        chk_rd(CONTROL_STATUS_ADDR, 24'h008000, "status");
        chk_rd(16'hFFF2, 24'h000000, "unmapped");
        wr(CLOCK_CONTROL_ADDR, 24'hFFFFFF);
        chk_rd(CLOCK_CONTROL_ADDR, 24'h0001FF, "clock fields");
        wr(CLOCK_CONTROL_ADDR, 24'h000008);
        tend("registers");
        wr(CONTROL_STATUS_ADDR, 24'h000001);
        cyc(4);
        n_sck = 0;
        n_pc = 0;
        n_si = 0;
        frame <= 1'b1;
        cyc(40);
        frame <= 1'b0;
        cyc(6);
        `CHK("slave oe", 1'b1, sck_oe_n_o)
        `CHK("slave generator", 0, n_sck)
        `CHK("peer edges", 5, n_si)
        `CHK("port clock", n_si, n_pc)
        tend("slave clock");
        wr(DATA_ADDR, 24'hA5A5A5);
        wr(CONTROL_STATUS_ADDR, 24'h000041);
        cyc(4);
        n_sck = 0;
        cyc(40);
        `CHK("master oe", 1'b0, sck_oe_n_o)
        `CHK("bit clock", 20, n_sck)
        `CHK("tx word", 24'hA5A5A5, tx_word_o)
        rd(CONTROL_STATUS_ADDR, d);
        `CHK("tx empty clear", 1'b0, d[TX_EMPTY_BIT])
        pulse(1, 24'h000000);
        rd(CONTROL_STATUS_ADDR, d);
        `CHK("tx empty set", 1'b1, d[TX_EMPTY_BIT])
        // clock fields change only while the port is held off
        wr(CONTROL_STATUS_ADDR, 24'h000040);
        wr(CLOCK_CONTROL_ADDR, 24'h00000E);
        cyc(4);
        `CHK("idle polarity", 1'b1, sck_out_o)
        wr(CONTROL_STATUS_ADDR, 24'h000041);
        cyc(4);
        n_sck = 0;
        cyc(64);
        `CHK("prescaled clock", 4, n_sck)
        wr(CONTROL_STATUS_ADDR, 24'h000001);
        tend("master clock");
        // sticky status bits are written as one so no write clears them
        wr(CONTROL_STATUS_ADDR, 24'h1C7C01);
        vec(VEC_TX_DATA, "tx data");
        pulse(0, 24'h000100);
        vec(VEC_TX_DATA, "tx over rx");
        wr(DATA_ADDR, 24'h123456);
        vec(VEC_RX_NOT_EMPTY, "rx not empty");
        for (int i = 1; i < 10; i++) pulse(0, 24'h000100 + 24'(i));
        vec(VEC_RX_FULL, "rx full");
        pulse(2, 24'h000000);
        vec(VEC_TX_UNDERRUN, "underrun");
        pulse(0, 24'hFFFFFF);
        vec(VEC_RX_OVERRUN, "overrun");
        pulse(3, 24'h000000);
        vec(VEC_BUS_ERROR, "bus error");
        wr(CONTROL_STATUS_ADDR, 24'h1C7801);
        vec(VEC_RX_OVERRUN, "bus masked");
        wr(CONTROL_STATUS_ADDR, 24'h1C5801);
        vec(VEC_TX_UNDERRUN, "rx1 masked");
        wr(CONTROL_STATUS_ADDR, 24'h1C5001);
        vec(VEC_RX_NOT_EMPTY, "tx masked");
        wr(CONTROL_STATUS_ADDR, 24'h1C4001);
        vec(16'h0000, "all masked");
        tend("events");
        for (int i = 0; i < 10; i++) begin
            rd(DATA_ADDR, d);
            `CHK("fifo order", 24'h000100 + 24'(i), d)
        end
        chk_rd(DATA_ADDR, 24'h000000, "empty read");
        tend("fifo");
        finish_test();
    end
endmodule : serial_host_clock_irq_map_tb_top
`default_nettype wire
